/* File: rtl/swcfg_defs.svh */
// constants of the configuration switch decoder
`ifndef SWCFG_DEFS_SVH
`define SWCFG_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SWCFG_ADDR_STATUS 5'h00
`define SWCFG_ADDR_SWITCH 5'h04
`define SWCFG_ADDR_LSS_NODE 5'h08
`define SWCFG_ADDR_LSS_RATE 5'h0c
`define SWCFG_ADDR_OD_IOCFG 5'h10

// ----------------------------------------------------------------
// decode values
// ----------------------------------------------------------------
`define SWCFG_NODE_BASE 7'h40
`define SWCFG_NODE_RSVD4 4'hf
`define SWCFG_NODE_RSVD6 6'h3f
`define SWCFG_NODE_MIN 7'h01
`define SWCFG_IO_DEF4 3'h0
`define SWCFG_IO_DEF6 3'h1
`define SWCFG_IO_MAX 3'h6
`define SWCFG_RATE_MAX 4'h8
`define SWCFG_RATE_1000 4'h0
`define SWCFG_RATE_500 4'h2
`define SWCFG_RATE_125 4'h4
`define SWCFG_RATE_20 4'h7

// ----------------------------------------------------------------
// switch sampling
// ----------------------------------------------------------------
`define SWCFG_SYNC_WAIT 2'h2

`endif

/* File: rtl/swcfg_pkg.sv */
// types of the configuration switch decoder
package swcfg_pkg;

  typedef enum logic [1:0] {SWCFG_SYNC, SWCFG_LOAD, SWCFG_RUN} swcfg_state_t;

  // network overrides, also the image kept in non-volatile storage
  typedef struct packed {
    logic node_set;
    logic [6:0] node;
    logic rate_set;
    logic [3:0] rate;
    logic io_set;
    logic [2:0] io;
  } swcfg_ovr_t;

endpackage

/* File: rtl/swcfg_decoder.sv */
// switch bank decoder with network overrides and register slave
//
// How it works
// R1: switch on reads one, off reads zero
// R2: four-bit node id is 0x40 plus offset
// R3: four-bit offset 0xf restores factory defaults
// R4: six-bit node id uses switches 6,7 high
// R5: six-bit setting giving 0x7f restores factory defaults
// R6: layer-set node id 1..127 overrides switches
// R7: layer-set node id change resets dictionary
// R8: two rate switches pick 20/125/500/1000
// R9: layer-set rate index 0..8 overrides switches
// R10: four-bit variant io config from switches 6,7
// R11: six-bit variant io starts at config 1
// R12: dictionary io write overrides switch selection
// R13: dictionary io change resets dictionary
// R14: standard 11-bit identifiers only
// R15: sample switches once after reset, then hold
// R16: overrides kept in non-volatile image
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`include "swcfg_defs.svh"

module swcfg_decoder (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] config_switch_bank,
  input wire logic variant_six_bit,
  input wire swcfg_pkg::swcfg_ovr_t nv_image_in,
  output swcfg_pkg::swcfg_ovr_t nv_image,
  output logic nv_store,
  output logic [6:0] node_id,
  output logic [3:0] rate_idx,
  output logic [2:0] iocfg,
  output logic cfg_valid,
  output logic factory_reset,
  output logic od_reset,
  output logic std_id_only,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import swcfg_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] sw_meta_r, sw_sync_r;
  logic var_meta_r, var_sync_r;

  // no reset: pin levels settle through the chain while rst is held
  always_ff @(posedge core_clk)
  begin
    sw_meta_r <= config_switch_bank;
    sw_sync_r <= sw_meta_r;
    var_meta_r <= variant_six_bit;
    var_sync_r <= var_meta_r;
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  swcfg_state_t state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic six_r, six_nxt;
  logic fdone_r, fdone_nxt;
  swcfg_ovr_t ovr_r, ovr_nxt;
  logic factory_r, factory_nxt;
  logic odrst_r, odrst_nxt;
  logic store_r, store_nxt;
  logic [6:0] node_r, node_nxt;
  logic [3:0] rate_r, rate_nxt;
  logic [2:0] io_r, io_nxt;
  logic valid_r, valid_nxt;
  logic stdid_r;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic wr_ok, rsvd_sw, node_wr_ok, rate_wr_ok, io_wr_ok;
  logic [6:0] sw_node;
  logic [3:0] sw_rate;

  // a write lands only on the edge that ends the bus wait
  assign wr_ok = avs_write && !wait_r;
  assign node_wr_ok = wr_ok && avs_address == `SWCFG_ADDR_LSS_NODE &&
                      avs_writedata[31:7] == 25'h0 &&
                      avs_writedata[6:0] >= `SWCFG_NODE_MIN; // R6
  assign rate_wr_ok = wr_ok && avs_address == `SWCFG_ADDR_LSS_RATE &&
                      avs_writedata[31:4] == 28'h0 &&
                      avs_writedata[3:0] <= `SWCFG_RATE_MAX; // R9
  assign io_wr_ok = wr_ok && avs_address == `SWCFG_ADDR_OD_IOCFG &&
                    avs_writedata[31:3] == 29'h0 &&
                    avs_writedata[2:0] <= `SWCFG_IO_MAX; // R12

  // closed switch is a one, so the synced level is used as is
  assign rsvd_sw = var_sync_r ?
    {sw_sync_r[7:6], sw_sync_r[3:0]} == `SWCFG_NODE_RSVD6 : // R5
    sw_sync_r[3:0] == `SWCFG_NODE_RSVD4; // R1 R3

  assign sw_node = six_r ?
    `SWCFG_NODE_BASE + {1'b0, hold_r[7:6], hold_r[3:0]} : // R4
    `SWCFG_NODE_BASE + {3'h0, hold_r[3:0]}; // R2

  always_comb
  begin
    case (hold_r[5:4]) // R8
      2'b01: sw_rate = `SWCFG_RATE_20;
      2'b00: sw_rate = `SWCFG_RATE_125;
      2'b10: sw_rate = `SWCFG_RATE_500;
      default: sw_rate = `SWCFG_RATE_1000;
    endcase
  end

  // ----------------------------------------------------------------
  // sampling, overrides and decoded outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    hold_nxt = hold_r;
    six_nxt = six_r;
    fdone_nxt = fdone_r;
    ovr_nxt = ovr_r;
    factory_nxt = 1'b0;
    odrst_nxt = 1'b0;
    store_nxt = 1'b0;
    case (state_r)
      SWCFG_SYNC:
      begin
        // wait until the synchroniser holds post-reset levels
        if (cnt_r == `SWCFG_SYNC_WAIT)
          state_nxt = SWCFG_LOAD;
        else
          cnt_nxt = cnt_r + 2'h1;
      end
      SWCFG_LOAD:
      begin
        hold_nxt = sw_sync_r; // R15
        six_nxt = var_sync_r;
        ovr_nxt = nv_image_in; // R16
        state_nxt = SWCFG_RUN;
        if (rsvd_sw)
        begin
          // factory default also wipes the stored overrides
          factory_nxt = 1'b1; // R3 R5
          fdone_nxt = 1'b1;
          ovr_nxt = '0;
          store_nxt = 1'b1;
        end
      end
      default:
      begin
        if (node_wr_ok)
        begin
          ovr_nxt.node_set = 1'b1; // R6
          ovr_nxt.node = avs_writedata[6:0];
          odrst_nxt = 1'b1; // R7
          store_nxt = 1'b1; // R16
        end
        if (rate_wr_ok)
        begin
          ovr_nxt.rate_set = 1'b1; // R9
          ovr_nxt.rate = avs_writedata[3:0];
          store_nxt = 1'b1;
        end
        if (io_wr_ok)
        begin
          ovr_nxt.io_set = 1'b1; // R12
          ovr_nxt.io = avs_writedata[2:0];
          odrst_nxt = 1'b1; // R13
          store_nxt = 1'b1;
        end
      end
    endcase
  end

  always_comb
  begin
    node_nxt = node_r;
    rate_nxt = rate_r;
    io_nxt = io_r;
    valid_nxt = state_r == SWCFG_RUN;
    if (state_r == SWCFG_RUN)
    begin
      if (ovr_r.node_set)
        node_nxt = ovr_r.node; // R6
      else if (fdone_r)
        node_nxt = `SWCFG_NODE_BASE;
      else
        node_nxt = sw_node; // R2 R4
      rate_nxt = ovr_r.rate_set ? ovr_r.rate : sw_rate; // R8 R9
      if (ovr_r.io_set)
        io_nxt = ovr_r.io; // R12
      else if (six_r)
        io_nxt = `SWCFG_IO_DEF6; // R11
      else
        io_nxt = {1'b0, hold_r[7:6]}; // R10
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= SWCFG_SYNC;
      cnt_r <= 2'h0;
      hold_r <= 8'h00;
      six_r <= 1'b0;
      fdone_r <= 1'b0;
      ovr_r <= '0;
      factory_r <= 1'b0;
      odrst_r <= 1'b0;
      store_r <= 1'b0;
      node_r <= `SWCFG_NODE_BASE;
      rate_r <= `SWCFG_RATE_125;
      io_r <= `SWCFG_IO_DEF4;
      valid_r <= 1'b0;
      stdid_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      hold_r <= hold_nxt;
      six_r <= six_nxt;
      fdone_r <= fdone_nxt;
      ovr_r <= ovr_nxt;
      factory_r <= factory_nxt;
      odrst_r <= odrst_nxt;
      store_r <= store_nxt;
      node_r <= node_nxt;
      rate_r <= rate_nxt;
      io_r <= io_nxt;
      valid_r <= valid_nxt;
      stdid_r <= 1'b1; // R14
    end
  end

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  // held in wait until the switches are sampled, so no write is lost
  always_comb
  begin
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if (state_r == SWCFG_RUN && wait_r && (avs_read || avs_write))
    begin
      wait_nxt = 1'b0;
      if (avs_read)
      begin
        if (avs_address == `SWCFG_ADDR_STATUS)
          rdata_nxt = {10'h0, valid_r, fdone_r, six_r, ovr_r.io_set,
                       ovr_r.rate_set, ovr_r.node_set, 1'b0, io_r,
                       rate_r, 1'b0, node_r};
        else if (avs_address == `SWCFG_ADDR_SWITCH)
          rdata_nxt = {24'h0, hold_r};
        else if (avs_address == `SWCFG_ADDR_LSS_NODE)
          rdata_nxt = {25'h0, ovr_r.node};
        else if (avs_address == `SWCFG_ADDR_LSS_RATE)
          rdata_nxt = {28'h0, ovr_r.rate};
        else if (avs_address == `SWCFG_ADDR_OD_IOCFG)
          rdata_nxt = {29'h0, ovr_r.io};
        else
          rdata_nxt = 32'h0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end
    else
    begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign nv_image = ovr_r;
  assign nv_store = store_r;
  assign node_id = node_r;
  assign rate_idx = rate_r;
  assign iocfg = io_r;
  assign cfg_valid = valid_r;
  assign factory_reset = factory_r;
  assign od_reset = odrst_r;
  assign std_id_only = stdid_r;
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_node4;
    @(posedge core_clk) disable iff (rst)
    state_r == SWCFG_RUN && !six_r && !ovr_r.node_set && !fdone_r
      |=> node_r == 7'h40 + {3'h0, $past(hold_r[3:0])};
  endproperty
  a_node4: assert property (p_node4) else $error("node id 4-bit"); // R2
  property p_rsvd4;
    @(posedge core_clk) disable iff (rst)
    state_r == SWCFG_LOAD && !var_sync_r && sw_sync_r[3:0] == 4'hf
      |=> factory_r && ovr_r == '0 ##1 !factory_r;
  endproperty
  a_rsvd4: assert property (p_rsvd4) else $error("no factory reset"); // R3
  property p_node6;
    @(posedge core_clk) disable iff (rst)
    state_r == SWCFG_RUN && six_r && !ovr_r.node_set && !fdone_r
      |=> node_r == 7'h40 + {1'b0, hold_r[7:6], hold_r[3:0]};
  endproperty
  a_node6: assert property (p_node6) else $error("node id 6-bit"); // R4
  property p_rsvd6;
    @(posedge core_clk) disable iff (rst)
    state_r == SWCFG_LOAD && var_sync_r &&
      sw_sync_r[7:6] == 2'b11 && sw_sync_r[3:0] == 4'hf |=> factory_r;
  endproperty
  a_rsvd6: assert property (p_rsvd6) else $error("no factory reset"); // R5
  property p_lss_node;
    @(posedge core_clk) disable iff (rst)
    node_wr_ok |=> odrst_r && store_r ##1
      node_r == $past(avs_writedata[6:0], 2);
  endproperty
  a_lss_node: assert property (p_lss_node) else $error("node ovr"); // R6 R7
  property p_rate_sw;
    @(posedge core_clk) disable iff (rst)
    state_r == SWCFG_RUN && !ovr_r.rate_set && hold_r[5:4] == 2'b01
      |=> rate_r == 4'h7;
  endproperty
  a_rate_sw: assert property (p_rate_sw) else $error("20k rate"); // R8
  property p_lss_rate;
    @(posedge core_clk) disable iff (rst)
    rate_wr_ok |-> ##2 rate_r == $past(avs_writedata[3:0], 2);
  endproperty
  a_lss_rate: assert property (p_lss_rate) else $error("rate ovr"); // R9
  property p_io4;
    @(posedge core_clk) disable iff (rst)
    state_r == SWCFG_RUN && !six_r && !ovr_r.io_set
      |=> io_r == {1'b0, $past(hold_r[7:6])};
  endproperty
  a_io4: assert property (p_io4) else $error("io from switches"); // R10
  property p_io6;
    @(posedge core_clk) disable iff (rst)
    state_r == SWCFG_RUN && six_r && !ovr_r.io_set |=> io_r == 3'h1;
  endproperty
  a_io6: assert property (p_io6) else $error("io default 1"); // R11
  property p_od_io;
    @(posedge core_clk) disable iff (rst)
    io_wr_ok |=> odrst_r ##1 io_r == $past(avs_writedata[2:0], 2);
  endproperty
  a_od_io: assert property (p_od_io) else $error("io ovr"); // R12 R13
  property p_hold;
    @(posedge core_clk) disable iff (rst)
    state_r == SWCFG_RUN |=> state_r == SWCFG_RUN && $stable(hold_r);
  endproperty
  a_hold: assert property (p_hold) else $error("switch sample moved"); // R15
  property p_stdid;
    @(posedge core_clk) disable iff (rst)
    valid_r |-> stdid_r;
  endproperty
  a_stdid: assert property (p_stdid) else $error("ext ids"); // R14
endmodule

/* File: dv/swcfg_partner.sv */
// partner model: switch bank and non-volatile override store
module swcfg_partner (
  input wire logic core_clk,
  input wire logic [7:0] sw_on,
  input wire logic nv_store,
  input wire swcfg_pkg::swcfg_ovr_t nv_image,
  output logic [7:0] config_switch_bank,
  output swcfg_pkg::swcfg_ovr_t nv_image_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import swcfg_pkg::*;

  // ----------------------------------------------------------------
  // switch bank
  // ----------------------------------------------------------------
  // a closed contact reads as one
  assign config_switch_bank = sw_on;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // no reset here: the image must outlive rst, like real storage
  initial
    nv_image_in = '0;
  always @(posedge core_clk)
    if (nv_store === 1'b1)
      nv_image_in <= nv_image;
endmodule

/* File: dv/test_switch_config_decoder.sv */
// self-checking bench of the configuration switch decoder
`include "swcfg_defs.svh"
module test_switch_config_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  import swcfg_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sw_on = 8'h00;
  logic variant_six_bit = 1'b0;
  logic [7:0] config_switch_bank;
  swcfg_ovr_t nv_image;
  swcfg_ovr_t nv_image_in;
  logic nv_store, cfg_valid, factory_reset, od_reset, std_id_only;
  logic [6:0] node_id;
  logic [3:0] rate_idx;
  logic [2:0] iocfg;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int error_cnt = 0;
  int checks_done = 0;
  int od_cnt = 0;
  int fr_cnt = 0;
  logic [31:0] rd;

  swcfg_decoder DUT (.core_clk, .rst, .config_switch_bank,
    .variant_six_bit, .nv_image_in, .nv_image, .nv_store, .node_id,
    .rate_idx, .iocfg, .cfg_valid, .factory_reset, .od_reset,
    .std_id_only, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest);

  swcfg_partner far_end (.core_clk, .sw_on, .nv_store, .nv_image,
    .config_switch_bank, .nv_image_in);

  initial
    forever
      #20 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    if (od_reset === 1'b1)
      od_cnt <= od_cnt + 1;
    if (factory_reset === 1'b1)
      fr_cnt <= fr_cnt + 1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic is_fac(input logic [7:0] s, input logic six);
    return six ? ({s[7:6], s[3:0]} == 6'h3f) : (s[3:0] == 4'hf);
  endfunction

  function automatic logic [6:0] exp_node(input logic [7:0] s,
                                          input logic six);
    if (is_fac(s, six))
      return 7'h40;
    return 7'h40 + (six ? {1'b0, s[7:6], s[3:0]} : {3'h0, s[3:0]});
  endfunction

  function automatic logic [3:0] exp_rate(input logic [1:0] r);
    case (r)
      2'b01: return 4'h7;
      2'b00: return 4'h4;
      2'b10: return 4'h2;
      default: return 4'h0;
    endcase
  endfunction

  // one Avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic start(input logic [7:0] s, input logic six);
    sw_on <= s;
    variant_six_bit <= six;
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 20 && cfg_valid !== 1'b1; i++)
      @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    chk(cfg_valid, 1'b1);
    chk(std_id_only, 1'b1);
  endtask

  task automatic chk_cfg(input logic [6:0] n, input logic [3:0] r,
                         input logic [2:0] io);
    chk(node_id, n);
    chk(rate_idx, r);
    chk(iocfg, io);
  endtask

  // ----------------------------------------------------------------
  // timeout
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4000) @(posedge core_clk);
    error_cnt++;
    $display("[ERR] %0t timeout", $time);
    finish_test();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    automatic logic [7:0] lf = 8'h3f;
    automatic logic [7:0] s;
    automatic logic six;
    automatic int f0;
    automatic int o0;
    // corners: both reserved settings, all open, highest non-reserved six-bit id (0x7e)
    automatic logic [7:0] corner [4] = '{8'h0f, 8'hcf, 8'h00, 8'hde};
    for (int k = 0; k < 28; k++)
    begin
      lf = lfsr(lf);
      s = (k < 4) ? corner[k] : lf;
      six = k[0];
      f0 = fr_cnt;
      start(s, six);
      chk(node_id, exp_node(s, six));
      chk(rate_idx, exp_rate(s[5:4]));
      chk(iocfg, six ? 3'h1 : {1'b0, s[7:6]});
      chk(fr_cnt - f0, is_fac(s, six) ? 1 : 0);
    end
    // overrides: out-of-range writes are ignored
    start(8'h25, 1'b0);
    o0 = od_cnt;
    bus(1'b1, `SWCFG_ADDR_LSS_NODE, 32'h0);
    bus(1'b1, `SWCFG_ADDR_LSS_NODE, 32'h80);
    bus(1'b1, `SWCFG_ADDR_LSS_RATE, 32'h9);
    bus(1'b1, `SWCFG_ADDR_OD_IOCFG, 32'h7);
    repeat (3) @(posedge core_clk);
    chk_cfg(7'h45, 4'h2, 3'h0);
    chk(od_cnt - o0, 0);
    bus(1'b1, `SWCFG_ADDR_LSS_NODE, 32'h7f);
    bus(1'b1, `SWCFG_ADDR_LSS_RATE, 32'h8);
    bus(1'b1, `SWCFG_ADDR_OD_IOCFG, 32'h6);
    sw_on <= 8'h0a;
    repeat (6) @(posedge core_clk);
    chk_cfg(7'h7f, 4'h8, 3'h6);
    chk(od_cnt - o0, 2);
    bus(1'b0, `SWCFG_ADDR_STATUS, 32'h0);
    chk(rd & 32'h000f7f7f, 32'h0007687f);
    bus(1'b0, `SWCFG_ADDR_SWITCH, 32'h0);
    chk(rd[7:0], 8'h25);
    bus(1'b0, 5'h14, 32'h0);
    chk(rd, 32'h0);
    // overrides outlive reset and win over new switches
    start(8'h4a, 1'b1);
    chk_cfg(7'h7f, 4'h8, 3'h6);
    // factory setting clears stored overrides
    start(8'h0f, 1'b0);
    chk_cfg(7'h40, 4'h4, 3'h0);
    start(8'h61, 1'b0);
    chk_cfg(7'h41, 4'h2, 3'h1);
    finish_test();
  end
endmodule
